/* src/qdcd_defs.vh */
// Constants of the quad DAC command decoder
`ifndef QDCD_DEFS_VH
`define QDCD_DEFS_VH
// ==========================================================
// Command word layout
`define QDCD_WORD_W 24
`define QDCD_RW_BIT 23
`define QDCD_RSV_BIT 22
`define QDCD_REG_HI 21
`define QDCD_REG_LO 19
`define QDCD_CH_HI 18
`define QDCD_CH_LO 16
`define QDCD_DATA_HI 15
`define QDCD_DATA_LO 0
`define QDCD_RANGE_HI 2
`define QDCD_RANGE_LO 0
`define QDCD_BITCNT_W 5
`define QDCD_LAST_BIT 5'h17
// ==========================================================
// Register select codes
`define QDCD_SEL_CODE 3'h0
`define QDCD_SEL_RANGE 3'h1
`define QDCD_SEL_POWER 3'h2
`define QDCD_SEL_CTRL 3'h3
// ==========================================================
// Channel codes
`define QDCD_CH_ALL 3'h4
`define QDCD_NUM_CH 4
// ==========================================================
// Range codes
`define QDCD_RNG_UNI5 3'h0
`define QDCD_RNG_UNI10 3'h1
`define QDCD_RNG_UNI108 3'h2
`define QDCD_RNG_BIP5 3'h3
`define QDCD_RNG_BIP10 3'h4
`define QDCD_RNG_BIP108 3'h5
// ==========================================================
// Reset values, resolution variants
`define QDCD_CODE_RST 16'h0000
`define QDCD_RANGE_RST 3'h0
`define QDCD_RES16 16
`define QDCD_RES14 14
`define QDCD_RES12 12
`endif

/* src/qdcd_pin_sync.v */
// Three-stage synchroniser for an asynchronous input pin
module qdcd_pin_sync #(
  parameter IDLE = 1'b0
) (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire pin_i,
  output reg level_o,
  output reg rise_o,
  output reg fall_o
);
  reg s1;
  reg s2;
  reg s3;
  // ==========================================================
  // Stage one is read only by stage two
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      // Reset to the pin's idle level, so release brings no false edge
      s1 <= IDLE;
      s2 <= IDLE;
      s3 <= IDLE;
      level_o <= IDLE;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
      // Change counts once stages two and three agree
      if (s2 == s3 && s3 != level_o) begin
        level_o <= s3;
        rise_o <= s3;
        fall_o <= ~s3;
      end
    end
  end
endmodule

/* src/qdcd_shifter.v */
// 24-bit serial input shift register with frame tracking
`include "qdcd_defs.vh"
module qdcd_shifter (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire frame_active_i,
  input wire frame_start_i,
  input wire frame_end_i,
  input wire bit_take_i,
  input wire bit_value_i,
  output reg [`QDCD_WORD_W-1:0] word_o,
  output reg word_valid_o
);
  reg [`QDCD_WORD_W-1:0] shift;
  reg [`QDCD_BITCNT_W-1:0] count;
  reg full;
  // ==========================================================
  // Word assembly, most significant bit first
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shift <= {`QDCD_WORD_W{1'b0}};
      count <= {`QDCD_BITCNT_W{1'b0}};
      full <= 1'b0;
      word_o <= {`QDCD_WORD_W{1'b0}};
      word_valid_o <= 1'b0;
    end else begin
      word_valid_o <= 1'b0;
      if (frame_start_i) begin
        count <= {`QDCD_BITCNT_W{1'b0}};
        full <= 1'b0;
      end else if (frame_active_i && bit_take_i && !full) begin
        shift <= {shift[`QDCD_WORD_W-2:0], bit_value_i};
        if (count == `QDCD_LAST_BIT)
          full <= 1'b1;
        else
          count <= count + 5'h01;
      end
      // A frame shorter than 24 bits is dropped whole; bits past the 24th are ignored
      if (frame_end_i && full) begin
        word_o <= shift;
        word_valid_o <= 1'b1;
        full <= 1'b0;
      end
    end
  end
endmodule

/* src/qdcd_top.v */
// Command decoder of a quad voltage-output DAC
//
// How it works
// - Host shifts 24-bit words, MSB first
// - Top bit selects read or write
// - Bits 21..19 pick the register class
// - Select 000 writes channel code register
// - Select 001 writes channel range register
// - Selects 010 and 011 routed outward
// - Channel 0..3 picks one, 4 all
// - Code write touches addressed channels only
// - 16-bit variant takes data bits 15..0
// - 14-bit variant takes bits 15..2
// - 12-bit variant takes bits 15..4
// - Range write touches addressed channels only
// - Range code from data bits 2..0
// - Six defined range codes, stored per channel
`include "qdcd_defs.vh"
module qdcd_top #(
  parameter RESOLUTION = `QDCD_RES16
) (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire serial_clock_i,
  input wire serial_sync_n_i,
  input wire serial_data_input_i,
  output reg [4*16-1:0] channel_code_register_o,
  output reg [4*3-1:0] channel_range_register_o,
  output reg [3:0] code_update_o,
  output reg [3:0] range_update_o,
  output reg power_write_o,
  output reg control_write_o,
  output reg read_request_o,
  output reg [2:0] read_register_select_o,
  output reg [2:0] read_channel_select_o,
  output reg [15:0] aux_data_o,
  output reg [2:0] aux_channel_select_o,
  output reg reserved_bit_error_o
);
  // ==========================================================
  // Pin synchronisation
  // Each pin costs four core cycles of delay; the serial clock must
  // stay high and low for at least two core cycles to be seen
  // Faster pin edges are lost, not half taken
  wire sclk_level;
  wire sclk_rise;
  wire sclk_fall;
  wire sync_level;
  wire sync_rise;
  wire sync_fall;
  wire serial_data_input_level;
  wire serial_data_input_rise;
  wire serial_data_input_fall;

  qdcd_pin_sync #(.IDLE(1'b1)) u_sclk_sync (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(serial_clock_i),
    .level_o(sclk_level),
    .rise_o(sclk_rise),
    .fall_o(sclk_fall)
  );

  qdcd_pin_sync #(.IDLE(1'b1)) u_sync_sync (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(serial_sync_n_i),
    .level_o(sync_level),
    .rise_o(sync_rise),
    .fall_o(sync_fall)
  );

  qdcd_pin_sync u_serial_data_input_sync (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(serial_data_input_i),
    .level_o(serial_data_input_level),
    .rise_o(serial_data_input_rise),
    .fall_o(serial_data_input_fall)
  );

  // ==========================================================
  // Word assembly
  // A word only counts once the frame pin rises again
  // Frames shorter than 24 bits leave no trace; longer ones keep their first 24 bits
  wire [`QDCD_WORD_W-1:0] word;
  wire word_valid;

  // Data is taken on the falling serial clock edge while frame is low
  qdcd_shifter u_shifter (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .frame_active_i(~sync_level),
    .frame_start_i(sync_fall),
    .frame_end_i(sync_rise),
    .bit_take_i(sclk_fall),
    .bit_value_i(serial_data_input_level),
    .word_o(word),
    .word_valid_o(word_valid)
  );

  // ==========================================================
  // Field split
  // Fields come from the held word, so they stay steady in the
  // cycle in which word_valid is high and after it
  wire rw_flag;
  wire reserved_bit;
  wire [2:0] register_select;
  wire [2:0] channel_select;
  wire [15:0] data_field;
  wire [2:0] range_code;
  wire register_select_bit2;
  wire register_select_bit1;
  wire register_select_bit0;
  wire channel_select_bit2;
  wire channel_select_bit1;
  wire channel_select_bit0;
  wire range_code_bit2;
  wire range_code_bit1;
  wire range_code_bit0;

  assign rw_flag = word[`QDCD_RW_BIT];
  assign reserved_bit = word[`QDCD_RSV_BIT];
  assign register_select_bit2 = word[`QDCD_REG_HI];
  assign register_select_bit1 = word[`QDCD_REG_HI-1];
  assign register_select_bit0 = word[`QDCD_REG_LO];
  assign register_select = {register_select_bit2, register_select_bit1,
    register_select_bit0};
  assign channel_select_bit2 = word[`QDCD_CH_HI];
  assign channel_select_bit1 = word[`QDCD_CH_HI-1];
  assign channel_select_bit0 = word[`QDCD_CH_LO];
  assign channel_select = {channel_select_bit2, channel_select_bit1,
    channel_select_bit0};
  assign data_field = word[`QDCD_DATA_HI:`QDCD_DATA_LO];
  assign range_code_bit2 = data_field[`QDCD_RANGE_HI];
  assign range_code_bit1 = data_field[`QDCD_RANGE_HI-1];
  assign range_code_bit0 = data_field[`QDCD_RANGE_LO];
  assign range_code = {range_code_bit2, range_code_bit1,
    range_code_bit0};

  // ==========================================================
  // Decode functions

  // One-hot channel mask, all ones for code four; codes five to seven give no channel
  function [3:0] chan_mask;
    input [2:0] sel;
    begin
      if (sel == `QDCD_CH_ALL)
        chan_mask = 4'hF;
      else if (sel[2])
        chan_mask = 4'h0;
      else
        chan_mask = 4'h1 << sel[1:0];
    end
  endfunction

  // Clears the don't-care low bits of narrower variants
  function [15:0] code_trim;
    input [15:0] d;
    begin
      if (RESOLUTION == `QDCD_RES12)
        code_trim = {d[15:4], 4'h0};
      else if (RESOLUTION == `QDCD_RES14)
        code_trim = {d[15:2], 2'h0};
      else
        code_trim = d;
    end
  endfunction

  // True for the six defined range codes
  function range_ok;
    input [2:0] r;
    begin
      range_ok = (r == `QDCD_RNG_UNI5) || (r == `QDCD_RNG_UNI10) ||
        (r == `QDCD_RNG_UNI108) || (r == `QDCD_RNG_BIP5) ||
        (r == `QDCD_RNG_BIP10) || (r == `QDCD_RNG_BIP108);
    end
  endfunction

  wire [3:0] mask;
  wire is_write;
  wire [15:0] trimmed;
  wire code_write;
  wire range_write;
  wire power_write;
  wire control_write;
  wire read_word;

  assign mask = chan_mask(channel_select);
  assign is_write = word_valid && !rw_flag;
  assign trimmed = code_trim(data_field);

  // ==========================================================
  // Write strobes, one per register class
  // At most one of them is high for any word
  // Reads never write, whatever their select field holds
  assign code_write = is_write &&
    (register_select == `QDCD_SEL_CODE);
  // An undefined range code drops the whole write, pulse included
  assign range_write = is_write &&
    (register_select == `QDCD_SEL_RANGE) && range_ok(range_code);
  assign power_write = is_write &&
    (register_select == `QDCD_SEL_POWER);
  assign control_write = is_write &&
    (register_select == `QDCD_SEL_CTRL);
  // Selects 100 to 111 fall through: no class takes them
  assign read_word = word_valid && rw_flag;

  // ==========================================================
  // Channel code storage
  // Channels outside the mask keep their code; 5..7 give an empty mask
  // Narrow variants store their unused low bits as zero
  integer i;

  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      channel_code_register_o <= {4{`QDCD_CODE_RST}};
      code_update_o <= 4'h0;
    end else begin
      code_update_o <= 4'h0;
      if (code_write) begin
        for (i = 0; i < `QDCD_NUM_CH; i = i + 1) begin
          if (mask[i])
            channel_code_register_o[i*16 +: 16] <= trimmed;
        end
        code_update_o <= mask;
      end
    end
  end

  // ==========================================================
  // Channel range storage
  // An undefined code never gets here, so stored ranges stay legal
  integer j;

  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      channel_range_register_o <= {4{`QDCD_RANGE_RST}};
      range_update_o <= 4'h0;
    end else begin
      range_update_o <= 4'h0;
      if (range_write) begin
        for (j = 0; j < `QDCD_NUM_CH; j = j + 1) begin
          if (mask[j])
            channel_range_register_o[j*3 +: 3] <= range_code;
        end
        range_update_o <= mask;
      end
    end
  end

  // ==========================================================
  // Power and control routing
  // Field meaning of these two classes lives in the blocks downstream
  // aux_* hold the last such write until the next one
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      power_write_o <= 1'b0;
      control_write_o <= 1'b0;
      aux_data_o <= 16'h0000;
      aux_channel_select_o <= 3'h0;
    end else begin
      power_write_o <= power_write;
      control_write_o <= control_write;
      if (power_write || control_write) begin
        aux_data_o <= data_field;
        aux_channel_select_o <= channel_select;
      end
    end
  end

  // ==========================================================
  // Read requests
  // Only the request leaves here; read data is another block's job
  // read_* hold the selects of the last read word
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      read_request_o <= 1'b0;
      read_register_select_o <= 3'h0;
      read_channel_select_o <= 3'h0;
    end else begin
      read_request_o <= read_word;
      if (read_word) begin
        read_register_select_o <= register_select;
        read_channel_select_o <= channel_select;
      end
    end
  end

  // ==========================================================
  // Reserved bit watch
  // Word still decoded; flag only shows the host broke the zero bit
  // A level, not a pulse: it reflects the last word only
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      reserved_bit_error_o <= 1'b0;
    else if (word_valid)
      reserved_bit_error_o <= reserved_bit;
  end
endmodule

/* tb/qdcd_checker_assertions.sv */
// Port assertions of the quad DAC command decoder
module qdcd_checker (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire serial_sync_n_i,
  input wire [63:0] channel_code_register_o,
  input wire [11:0] channel_range_register_o,
  input wire [3:0] code_update_o,
  input wire [3:0] range_update_o,
  input wire power_write_o,
  input wire control_write_o,
  input wire read_request_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Cycles since the frame pin rose; updates may only follow a frame end
  logic [3:0] since_end;
  wire [3:0] cu = code_update_o;
  wire [3:0] ru = range_update_o;
  wire [63:0] code = channel_code_register_o;
  wire [11:0] rng = channel_range_register_o;
  wire [4:0] hit = {|cu, |ru, power_write_o, control_write_o,
    read_request_o};
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      since_end <= 4'hF;
    else if ($rose(serial_sync_n_i))
      since_end <= 4'h0;
    else if (since_end != 4'hF)
      since_end <= since_end + 4'h1;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ====================
  // Assertions
  chk_code_mask_shape: assert property ($onehot0(cu) || cu == 4'hF)
    else $error("bad code mask");
  chk_range_mask_shape: assert property ($onehot0(ru) || ru == 4'hF)
    else $error("bad range mask");
  chk_code_pulse_short: assert property (|cu |=> cu == 4'h0)
    else $error("code pulse too long");
  chk_code_write_mask: assert property (!$stable(code) |-> |cu)
    else $error("code changed without pulse");
  chk_range_write_mask: assert property (!$stable(rng) |-> |ru)
    else $error("range changed without pulse");
  chk_range_code_legal: assert property ((rng[2:0] < 3'h6)
    && (rng[5:3] < 3'h6) && (rng[8:6] < 3'h6) && (rng[11:9] < 3'h6))
    else $error("undefined range stored");
  chk_class_exclusive: assert property ($onehot0(hit))
    else $error("two register classes at once");
  chk_update_after_frame: assert property (|hit |-> since_end inside {[2:9]})
    else $error("update away from frame end");
  cover property (cu == 4'hF);
  cover property (|ru);
  cover property (power_write_o || control_write_o || read_request_o);
endmodule
bind qdcd_top qdcd_checker chk_u (.core_clk_i(core_clk_i),
  .sys_rst_i(sys_rst_i), .serial_sync_n_i(serial_sync_n_i),
  .channel_code_register_o(channel_code_register_o),
  .channel_range_register_o(channel_range_register_o),
  .code_update_o(code_update_o), .range_update_o(range_update_o),
  .power_write_o(power_write_o), .control_write_o(control_write_o),
  .read_request_o(read_request_o));

/* tb/qdcd_host_model.sv */
// Behavioural serial host that frames and shifts command words
module qdcd_host_model (
  output logic sclk_o,
  output logic sync_n_o,
  output logic sdi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clock idles high so the first falling edge carries the first bit
  initial begin
    sclk_o = 1'b1;
    sync_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // A frame shorter than 24 bits is sent by giving fewer bits
  task automatic send(input logic [23:0] word, input int nbits = 24);
    sync_n_o = 1'b0;
    for (int i = 23; i > 23 - nbits; i--) begin
      sdi_o = word[i];
      #80.7 sclk_o = 1'b0;
      #79.3 sclk_o = 1'b1;
    end
    #80 sync_n_o = 1'b1;
    // Released line shows the inverse, so a stale bit cannot pass
    sdi_o = ~sdi_o;
  endtask
endmodule

/* tb/test_quad_dac_command_decoder.sv */
// Self-checking bench of the quad DAC command decoder
`include "qdcd_defs.vh"
module test_quad_dac_command_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  wire sclk, sync_n, sdi, pwr, ctl, rd, rsv;
  wire [63:0] code;
  wire [127:0] code_n;
  wire [11:0] rng;
  wire [15:0] aux_d;
  wire [3:0] cu, ru;
  wire [2:0] rd_sel, rd_ch, aux_ch;
  logic [3:0] seen_c = 4'h0;
  logic [3:0] seen_r = 4'h0;
  logic [2:0] seen_m = 3'h0;
  logic [63:0] exp_code = 64'h0;
  int mismatches = 0;
  int tests_run = 0;
  always #2.5 core_clk_i = ~core_clk_i;
  // ====================
  // Host and decoders; the narrow variants share the same pins
  qdcd_host_model host_u (.sclk_o(sclk), .sync_n_o(sync_n), .sdi_o(sdi));
  qdcd_top dut_u (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .serial_clock_i(sclk), .serial_sync_n_i(sync_n),
    .serial_data_input_i(sdi), .channel_code_register_o(code),
    .channel_range_register_o(rng), .code_update_o(cu),
    .range_update_o(ru), .power_write_o(pwr), .control_write_o(ctl),
    .read_request_o(rd), .read_register_select_o(rd_sel),
    .read_channel_select_o(rd_ch), .aux_data_o(aux_d),
    .aux_channel_select_o(aux_ch), .reserved_bit_error_o(rsv));
  for (genvar g = 0; g < 2; g++) begin : narrow
    qdcd_top #(.RESOLUTION(g ? `QDCD_RES12 : `QDCD_RES14)) dut_n (
      .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
      .serial_clock_i(sclk), .serial_sync_n_i(sync_n),
      .serial_data_input_i(sdi),
      .channel_code_register_o(code_n[64*g +: 64]),
      .channel_range_register_o(), .code_update_o(), .range_update_o(),
      .power_write_o(), .control_write_o(), .read_request_o(),
      .read_register_select_o(), .read_channel_select_o(),
      .aux_data_o(), .aux_channel_select_o(), .reserved_bit_error_o());
  end
  // ====================
  // Tasks
  function automatic logic [23:0] cmd(input logic rw, input logic [2:0] s,
    input logic [2:0] ch, input logic [15:0] d);
    return {rw, 1'b0, s, ch, d};
  endfunction
  task automatic check(input logic [63:0] got, input logic [63:0] want);
    tests_run++;
    if (got !== want) begin
      mismatches++;
      $display("Error %0t: saw %h, expected %h", $time, got, want);
    end
  endtask
  // Pulses last one cycle, so they are caught here and judged later;
  // an open frame clears them, so each transfer starts clean
  always @(posedge core_clk_i) begin
    if (!sync_n) begin
      seen_c <= 4'h0;
      seen_r <= 4'h0;
      seen_m <= 3'h0;
    end else begin
      if (|cu) seen_c <= cu;
      if (|ru) seen_r <= ru;
      if (pwr | ctl | rd) seen_m <= {pwr, ctl, rd};
    end
  end
  task automatic xfer(input logic [23:0] w, input int nbits = 24);
    host_u.send(w, nbits);
    repeat (12) @(negedge core_clk_i);
  endtask
  task automatic final_report;
    if (mismatches == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ====================
  // Scenarios
  initial begin
    repeat (3) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    repeat (6) @(negedge core_clk_i);
    check(code, 64'h0);
    check({52'h0, rng}, 64'h0);
    for (int i = 0; i < 4; i++) begin
      xfer(cmd(1'b0, `QDCD_SEL_CODE, i[2:0], 16'hA5C3 + i[15:0]));
      exp_code[16*i +: 16] = 16'hA5C3 + i[15:0];
      check(code, exp_code);
      check(seen_c, 4'h1 << i);
    end
    xfer(cmd(1'b0, `QDCD_SEL_CODE, `QDCD_CH_ALL, 16'h8BCF));
    check(code, {4{16'h8BCF}});
    check(seen_c, 4'hF);
    check(code_n[63:0], {4{16'h8BCC}});
    check(code_n[127:64], {4{16'h8BC0}});
    for (int i = 5; i < 8; i++) begin
      xfer(cmd(1'b0, `QDCD_SEL_CODE, i[2:0], 16'h1234));
      check(seen_c, 4'h0);
      check(code, {4{16'h8BCF}});
    end
    xfer(cmd(1'b0, `QDCD_SEL_CODE, `QDCD_CH_ALL, 16'h8BCF) | 24'h400000);
    check({seen_c, rsv}, {4'hF, 1'b1});
    xfer(cmd(1'b0, `QDCD_SEL_CODE, `QDCD_CH_ALL, 16'h0000), 23);
    check({seen_c, rsv}, {4'h0, 1'b1});
    check(code, {4{16'h8BCF}});
    for (int i = 0; i < 6; i++) begin
      xfer(cmd(1'b0, `QDCD_SEL_RANGE, 3'h1, 16'hFFF8 | i[15:0]));
      check({seen_r, rng}, {4'h2, 6'h0, i[2:0], 3'h0});
    end
    for (int i = 6; i < 8; i++) begin
      xfer(cmd(1'b0, `QDCD_SEL_RANGE, 3'h1, i[15:0]));
      check({seen_r, rng}, {4'h0, 12'h028});
    end
    xfer(cmd(1'b0, `QDCD_SEL_RANGE, `QDCD_CH_ALL, 16'hFFFB));
    check({seen_r, rng}, {4'hF, 12'h6DB});
    xfer(cmd(1'b0, `QDCD_SEL_POWER, 3'h0, 16'h0781));
    check({aux_ch, aux_d, seen_m}, {3'h0, 16'h0781, 3'h4});
    xfer(cmd(1'b0, `QDCD_SEL_CTRL, 3'h4, 16'h0009));
    check({aux_ch, aux_d, seen_m}, {3'h4, 16'h0009, 3'h2});
    xfer(cmd(1'b1, `QDCD_SEL_CODE, 3'h2, 16'h5555));
    check(code, {4{16'h8BCF}});
    check({rd_sel, rd_ch, seen_m, seen_c}, {9'h011, 4'h0});
    check(rsv, 1'b0);
    final_report();
  end
endmodule
